// *** hw/rgs_pkg.sv ***
// Constants for the regulator enable sequencer: register map, fields, reset values, warm-up counts.
// Assumes a 25 MHz system clock and a plain one-cycle register port.
// Behaviour
// - On enable the NVM supply trickle-charges, then drives full current after 200 us.
// - With an external 1.8 V source selected, the NVM supply enable is ignored.
// - With the buck already on the NVM regulator is bypassed but still needs its enable and 200 us.
// - The analog current select resets to code 1, meaning 20 mA.
// - An analog supply ready flag shows when the enabled analog regulators are fully on.
// - Enabling the analog regulators moves the radio into its run state.
// - Writing one to the NVM supply enable turns it on, zero turns it off; it resets to zero.
package rgs_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CONTROL = 8'h48;
    localparam logic [7:0] REG_STATUS = 8'h4c;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h50;
    localparam logic [7:0] REG_IRQ_MASK = 8'h54;
    localparam logic [7:0] REG_POWER_SOURCE = 8'h58;
    // ==========================================================
    // Control fields
    localparam int BUCK_EN_BIT = 0;
    localparam int NVM_EN_BIT = 7;
    localparam int ANA_EN_LSB = 3;
    localparam int ANA_SEL_LSB = 5;
    localparam int BUCK_DIV_LSB = 8;
    localparam logic [31:0] CONTROL_WMASK = 32'h00001fff;
    localparam logic [31:0] CONTROL_RESET = 32'h00000f20;
    localparam logic [1:0] ANA_SEL_RESET = 2'h1;
    localparam logic [1:0] ANA_EN_RESET = 2'h0;
    localparam logic [1:0] PWR_EXT_1P8 = 2'h2;
    localparam logic [1:0] PWR_SRC_RESET = 2'h0;
    // Status and interrupt bits.
    localparam int ST_NVM_RDY = 0;
    localparam int ST_ANA_RDY = 1;
    localparam int ST_RADIO_RUN = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // ==========================================================
    // Timing
    localparam int CLOCK_HZ = 25000000;
    localparam int NVM_WARM_US = 200;
    localparam int NVM_WARM_CYC = NVM_WARM_US * (CLOCK_HZ / 1000000);
    localparam int ANA_WARM_US = 100;
    localparam int ANA_WARM_CYC = ANA_WARM_US * (CLOCK_HZ / 1000000);
    localparam int CNT_W = 16;
    typedef enum logic [1:0] {
        SUP_OFF = 2'b00,
        SUP_CHARGE = 2'b01,
        SUP_READY = 2'b10
    } rgs_sup_t;
endpackage

// *** hw/rgs_sequencer.sv ***
// Regulator enable sequencer: control register, supply warm-up, status and interrupt.
// Assumes a single 25 MHz clock and a register master that never waits.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module rgs_sequencer (
    // System
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Regulator and radio controls
    output logic nvmSupplyOn,
    output logic nvmFullDrive,
    output logic [1:0] analogSupplyEnable,
    output logic [1:0] analogSupplyCurrentSelect,
    output logic radioRun,
    output logic irq
);
    // ==========================================================
    // Registers
    logic [31:0] control_r;
    logic [1:0] powerSource_r;
    logic [2:0] irqStatus_r;
    logic [2:0] irqMask_r;
    logic [31:0] regRdata_r;
    logic nvmRdyD_r;
    logic anaRdyD_r;
    logic runD_r;
    logic irq_r;
    logic nvmReady;
    logic anaReady;
    logic nvmCharging;
    logic nvmEnEff;
    logic anaEnAny;
    logic [2:0] statusNow;
    logic [2:0] events;

    // The external 1.8 V source removes the regulator from the path entirely.
    assign nvmEnEff = control_r[rgs_pkg::NVM_EN_BIT] && (powerSource_r != rgs_pkg::PWR_EXT_1P8);
    assign anaEnAny = |control_r[rgs_pkg::ANA_EN_LSB +: 2];

    // ==========================================================
    // Control register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            control_r <= rgs_pkg::CONTROL_RESET;
        end else if (regWrite && regAddr == rgs_pkg::REG_CONTROL) begin
            control_r <= regWdata & rgs_pkg::CONTROL_WMASK;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            powerSource_r <= rgs_pkg::PWR_SRC_RESET;
        end else if (regWrite && regAddr == rgs_pkg::REG_POWER_SOURCE) begin
            powerSource_r <= regWdata[1:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqMask_r <= rgs_pkg::IRQ_MASK_RESET;
        end else if (regWrite && regAddr == rgs_pkg::REG_IRQ_MASK) begin
            irqMask_r <= regWdata[2:0];
        end
    end

    // ==========================================================
    // Warm-up timers
    // With the buck on the regulator is bypassed, but the capacitor still needs the same time.
    rgs_warmup #(.CYCLES(rgs_pkg::NVM_WARM_CYC)) nvmTimer (
        .clock(clock),
        .rstn(rstn),
        .enable(nvmEnEff),
        .ready(nvmReady),
        .charging(nvmCharging)
    );

    rgs_warmup #(.CYCLES(rgs_pkg::ANA_WARM_CYC)) anaTimer (
        .clock(clock),
        .rstn(rstn),
        .enable(anaEnAny),
        .ready(anaReady),
        .charging()
    );

    // ==========================================================
    // Outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nvmSupplyOn <= 1'b0;
            nvmFullDrive <= 1'b0;
            analogSupplyEnable <= rgs_pkg::ANA_EN_RESET;
            analogSupplyCurrentSelect <= rgs_pkg::ANA_SEL_RESET;
            radioRun <= 1'b0;
        end else begin
            // The buck bypasses the regulator, so only the capacitor is charged then.
            nvmSupplyOn <= nvmEnEff && !control_r[rgs_pkg::BUCK_EN_BIT];
            nvmFullDrive <= nvmReady && !control_r[rgs_pkg::BUCK_EN_BIT];
            analogSupplyEnable <= control_r[rgs_pkg::ANA_EN_LSB +: 2];
            analogSupplyCurrentSelect <= control_r[rgs_pkg::ANA_SEL_LSB +: 2];
            radioRun <= anaEnAny;
        end
    end

    assign statusNow = {radioRun, anaReady, nvmReady};

    // ==========================================================
    // Interrupts: rising ready or run edges are sticky until the interrupt status register is read.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nvmRdyD_r <= 1'b0;
            anaRdyD_r <= 1'b0;
            runD_r <= 1'b0;
        end else begin
            nvmRdyD_r <= nvmReady;
            anaRdyD_r <= anaReady;
            runD_r <= radioRun;
        end
    end

    assign events = {radioRun & ~runD_r, anaReady & ~anaRdyD_r, nvmReady & ~nvmRdyD_r};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqStatus_r <= 3'h0;
        end else if (regRead && regAddr == rgs_pkg::REG_IRQ_STATUS) begin
            irqStatus_r <= events;
        end else begin
            irqStatus_r <= irqStatus_r | events;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |((irqStatus_r | events) & irqMask_r);
        end
    end
    assign irq = irq_r;

    // ==========================================================
    // Read port
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdata_r <= 32'h0;
        end else if (regRead) begin
            if (regAddr == rgs_pkg::REG_CONTROL) begin
                regRdata_r <= control_r;
            end else if (regAddr == rgs_pkg::REG_STATUS) begin
                regRdata_r <= {29'h0, statusNow};
            end else if (regAddr == rgs_pkg::REG_IRQ_STATUS) begin
                regRdata_r <= {29'h0, irqStatus_r};
            end else if (regAddr == rgs_pkg::REG_IRQ_MASK) begin
                regRdata_r <= {29'h0, irqMask_r};
            end else if (regAddr == rgs_pkg::REG_POWER_SOURCE) begin
                regRdata_r <= {30'h0, powerSource_r};
            end else begin
                regRdata_r <= 32'h0;
            end
        end else begin
            regRdata_r <= 32'h0;
        end
    end
    assign regRdata = regRdata_r;

    // ==========================================================
    // Checks
    localparam int NVM_CYC = rgs_pkg::NVM_WARM_CYC;
    logic [15:0] nvmOnCnt_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nvmOnCnt_r <= 16'h0;
        end else if (!nvmEnEff) begin
            nvmOnCnt_r <= 16'h0;
        end else if (nvmOnCnt_r != 16'hffff) begin
            nvmOnCnt_r <= nvmOnCnt_r + 16'h1;
        end
    end

    a_nvm_ready_time: assert property (@(posedge clock) disable iff (!rstn)
        nvmReady |-> nvmOnCnt_r >= 16'(NVM_CYC)) else $error("NVM ready before warm-up");
    a_nvm_ready_due: assert property (@(posedge clock) disable iff (!rstn)
        (nvmEnEff && nvmOnCnt_r == 16'(NVM_CYC + 1)) |-> nvmReady) else $error("NVM ready late");
    a_ext_ignore: assert property (@(posedge clock) disable iff (!rstn)
        powerSource_r == rgs_pkg::PWR_EXT_1P8 |-> ##1 !nvmSupplyOn) else $error("NVM on with external source");
    a_buck_bypass: assert property (@(posedge clock) disable iff (!rstn)
        control_r[rgs_pkg::BUCK_EN_BIT] |-> ##1 !nvmFullDrive) else $error("Full drive while bypassed");
    a_sel_reset: assert property (@(posedge clock)
        $rose(rstn) |-> analogSupplyCurrentSelect == rgs_pkg::ANA_SEL_RESET) else $error("Select reset wrong");
    a_ana_ready_low: assert property (@(posedge clock) disable iff (!rstn)
        !anaEnAny |-> ##1 !anaReady) else $error("Analog ready while off");
    a_radio_run: assert property (@(posedge clock) disable iff (!rstn)
        anaEnAny |-> ##1 radioRun) else $error("Radio not running");
    a_enable_write: assert property (@(posedge clock) disable iff (!rstn)
        (regWrite && regAddr == rgs_pkg::REG_CONTROL) |=> control_r[7] == $past(regWdata[7])) else $error("Enable write");
    a_ready_clear: assert property (@(posedge clock) disable iff (!rstn)
        $fell(nvmEnEff) |-> ##1 !nvmReady) else $error("NVM ready not cleared");
    c_nvm_ready: cover property (@(posedge clock) disable iff (!rstn) $rose(nvmReady));
    c_ana_ready: cover property (@(posedge clock) disable iff (!rstn) $rose(anaReady));
    c_irq: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
    c_charging: cover property (@(posedge clock) disable iff (!rstn) nvmCharging && control_r[0]);
endmodule
`default_nettype wire

// *** hw/rgs_warmup.sv ***
// One supply warm-up timer: counts cycles from enable to ready.
// Assumes enable is a synchronous level from the same clock.
`timescale 1ns/10ps
`default_nettype none
module rgs_warmup #(
    parameter int unsigned CYCLES = 5000
) (
    // System
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic enable,
    output logic ready,
    output logic charging
);
    // ==========================================================
    // Warm-up state machine
    localparam int CNT_W = rgs_pkg::CNT_W;
    rgs_pkg::rgs_sup_t state_r;
    logic [rgs_pkg::CNT_W-1:0] count_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= rgs_pkg::SUP_OFF;
            count_r <= '0;
        end else if (!enable) begin
            state_r <= rgs_pkg::SUP_OFF;
            count_r <= '0;
        end else begin
            case (state_r)
                rgs_pkg::SUP_OFF: begin
                    state_r <= rgs_pkg::SUP_CHARGE;
                    count_r <= '0;
                end
                rgs_pkg::SUP_CHARGE: begin
                    if (count_r == CNT_W'(CYCLES - 2)) begin
                        state_r <= rgs_pkg::SUP_READY;
                    end
                    count_r <= count_r + 1'b1;
                end
                default: state_r <= rgs_pkg::SUP_READY;
            endcase
        end
    end

    assign ready = (state_r == rgs_pkg::SUP_READY);
    assign charging = (state_r == rgs_pkg::SUP_CHARGE);
endmodule
`default_nettype wire

// *** verification/test_regulator_enable_sequencer.sv ***
// Self-checking bench for the regulator enable sequencer, driven over its register port.
// Assumes rgs_pkg and rgs_sequencer are compiled first; one 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_regulator_enable_sequencer;
    // ==========================================================
    // Design connections
    logic clock;
    logic rstn;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [31:0] regRdata;
    logic nvmSupplyOn;
    logic nvmFullDrive;
    logic [1:0] analogSupplyEnable;
    logic [1:0] analogSupplyCurrentSelect;
    logic radioRun;
    logic irq;
    int badCount;
    int nChecks;
    logic [31:0] rdVal;
    typedef struct {logic [31:0] data; logic [1:0] en; logic [1:0] sel; logic run;} rgs_tb_row_t;
    // Reserved bits in the last row must read back as zero.
    rgs_tb_row_t rows [5] = '{'{32'h48, 2'h1, 2'h2, 1'b1}, '{32'h20, 2'h0, 2'h1, 1'b0},
        '{32'h18, 2'h3, 2'h0, 1'b1}, '{32'h70, 2'h2, 2'h3, 1'b1}, '{32'hffffe000, 2'h0, 2'h0, 1'b0}};

    rgs_sequencer dut_u (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .nvmSupplyOn(nvmSupplyOn),
        .nvmFullDrive(nvmFullDrive), .analogSupplyEnable(analogSupplyEnable),
        .analogSupplyCurrentSelect(analogSupplyCurrentSelect), .radioRun(radioRun), .irq(irq));

    // ==========================================================
    // Clock and bus tasks
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample at that falling edge.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        d = regRdata;
    endtask

    task automatic chkReg(input string n, input logic [31:0] e, input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkPin(input string n, input logic [1:0] e, input logic [1:0] g);
        nChecks++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Warm-ups dominate the run; the limit leaves well over twice their sum.
    initial begin
        repeat (30000) @(posedge clock);
        badCount++;
        giveVerdict();
    end

    // ==========================================================
    // Tests
    initial begin
        rstn = 1'b0;
        regAddr = 8'h0;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        badCount = 0;
        nChecks = 0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chkPin("select", rgs_pkg::ANA_SEL_RESET, analogSupplyCurrentSelect);
        chkPin("enable", rgs_pkg::ANA_EN_RESET, analogSupplyEnable);
        chkPin("nvm on", 2'h0, {1'b0, nvmSupplyOn});
        rd(rgs_pkg::REG_CONTROL, rdVal);
        chkReg("control", rgs_pkg::CONTROL_RESET, rdVal);
        rd(rgs_pkg::REG_IRQ_MASK, rdVal);
        chkReg("mask", 32'h0, rdVal);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h0, rdVal);
        wr(8'h10, 32'hffffffff);
        rd(8'h10, rdVal);
        chkReg("unmapped", 32'h0, rdVal);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(rgs_pkg::REG_CONTROL, rows[i].data);
            repeat (3) @(posedge clock);
            rd(rgs_pkg::REG_CONTROL, rdVal);
            chkReg("control", rows[i].data & rgs_pkg::CONTROL_WMASK, rdVal);
            chkPin("enable", rows[i].en, analogSupplyEnable);
            chkPin("select", rows[i].sel, analogSupplyCurrentSelect);
            chkPin("run", {1'b0, rows[i].run}, {1'b0, radioRun});
        end
        $display("test field rows done");
        wr(rgs_pkg::REG_CONTROL, 32'hb8);
        repeat (rgs_pkg::ANA_WARM_CYC - 50) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h4, rdVal);
        chkPin("drive", 2'h2, {nvmSupplyOn, nvmFullDrive});
        repeat (100) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h6, rdVal);
        repeat (rgs_pkg::NVM_WARM_CYC - rgs_pkg::ANA_WARM_CYC - 150) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h6, rdVal);
        repeat (200) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h7, rdVal);
        chkPin("drive", 2'h3, {nvmSupplyOn, nvmFullDrive});
        chkPin("irq", 2'h0, {1'b0, irq});
        wr(rgs_pkg::REG_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clock);
        chkPin("irq", 2'h1, {1'b0, irq});
        rd(rgs_pkg::REG_IRQ_STATUS, rdVal);
        chkReg("events", 32'h7, rdVal);
        repeat (2) @(posedge clock);
        chkPin("irq", 2'h0, {1'b0, irq});
        rd(rgs_pkg::REG_IRQ_STATUS, rdVal);
        chkReg("events", 32'h0, rdVal);
        wr(rgs_pkg::REG_CONTROL, 32'h20);
        repeat (3) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h0, rdVal);
        chkPin("drive", 2'h0, {nvmSupplyOn, nvmFullDrive});
        $display("test warm-up done");
        wr(rgs_pkg::REG_CONTROL, 32'h21);
        wr(rgs_pkg::REG_CONTROL, 32'ha1);
        repeat (rgs_pkg::NVM_WARM_CYC - 100) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h0, rdVal);
        repeat (200) @(posedge clock);
        rd(rgs_pkg::REG_STATUS, rdVal);
        chkReg("status", 32'h1, rdVal);
        chkPin("drive", 2'h0, {nvmSupplyOn, nvmFullDrive});
        chkPin("irq", 2'h1, {1'b0, irq});
        wr(rgs_pkg::REG_CONTROL, 32'h20);
        rd(rgs_pkg::REG_IRQ_STATUS, rdVal);
        chkReg("events", 32'h1, rdVal);
        $display("test buck bypass done");
        wr(rgs_pkg::REG_POWER_SOURCE, {30'h0, rgs_pkg::PWR_EXT_1P8});
        rd(rgs_pkg::REG_POWER_SOURCE, rdVal);
        chkReg("source", {30'h0, rgs_pkg::PWR_EXT_1P8}, rdVal);
        wr(rgs_pkg::REG_CONTROL, 32'ha0);
        repeat (3) @(posedge clock);
        chkPin("drive", 2'h0, {nvmSupplyOn, nvmFullDrive});
        $display("test external source done");
        giveVerdict();
    end
endmodule
`default_nettype wire
